// >>> watchdog_timer_7bit_tb.sv
// Self-checking testbench for the seven-bit watchdog timer.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_7bit_tb;
    // Clock, reset and register port.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    // Power pins, RC source and outputs.
    logic stop_mode = 1'b0;
    logic sub_clock_mode = 1'b0;
    logic rc_osc = 1'b0;
    logic chip_reset_n;
    logic main_osc_on;
    logic irq;
    // Bookkeeping of the run.
    int err_count = 0;
    int checked = 0;
    int rc_rises = 0;
    int phase = 0;
    int n;
    logic rc_run = 1'b0;
    logic [7:0] v;
    logic [7:0] w;

    wdt_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .stop_mode(stop_mode), .sub_clock_mode(sub_clock_mode),
        .rc_osc(rc_osc), .chip_reset_n(chip_reset_n),
        .main_osc_on(main_osc_on), .irq(irq));

    // Free-running system clock.
    always #5 clk = ~clk;

    // RC source: a slow period so the synchroniser catches every edge.
    always @(posedge clk) begin
        if (rc_run) begin
            phase <= (phase == 4) ? 0 : phase + 1;
            if (phase == 4) begin
                rc_osc <= ~rc_osc;
                if (!rc_osc) rc_rises <= rc_rises + 1;
            end
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Compares one value with its expectation.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // One-cycle register read; data stand only in the following cycle.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 0;
        #1 d = rdata;
    endtask : rd

    // Bounded wait for irq high (sel 0) or chip reset low (sel 1).
    task automatic wait_ev(input bit sel, input int bound);
        int i;
        i = 0;
        while ((sel ? chip_reset_n !== 1'b0 : irq !== 1'b1) && i < bound) begin
            @(posedge clk);
            #1 i++;
        end
        if (i >= bound) begin
            err_count++;
            report_and_stop();
        end
    endtask : wait_ev

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped read, chip reset released.
        rd(wdt_pkg::status_off, v); chk(v, 8'h00);
        rd(wdt_pkg::mask_off, v); chk(v, 8'h00);
        rd(wdt_pkg::count_off, v); chk(v, 8'h00);
        rd(wdt_pkg::compare_off, v); chk(v, 8'h7f);
        rd(4'hf, v); chk(v, 8'h00);
        chk({7'h0, chip_reset_n}, 8'h01);
        $display("test reset values done");
        // Interrupt mode: the flag sets while masked, then irq follows.
        wr(wdt_pkg::compare_off, 8'h82);
        n = 0;
        v = 8'h00;
        while (v[0] !== 1'b1 && n < 8000) begin
            rd(wdt_pkg::status_off, v);
            n++;
        end
        chk({7'h0, v[0]}, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(wdt_pkg::mask_off, 8'h01);
        wait_ev(1'b0, 20000);
        chk({7'h0, chip_reset_n}, 8'h01);
        rd(wdt_pkg::status_off, v); chk(v & 8'h01, 8'h01);
        @(posedge clk);
        #1 chk({7'h0, irq}, 8'h00);
        $display("test interrupt done");
        // Counter clear bit clears the count and reads back as zero.
        // Slowest prescale keeps a tick from landing before the read.
        wr(wdt_pkg::clkctl_off, 8'h0f);
        wr(wdt_pkg::compare_off, 8'hff);
        @(posedge clk);
        rd(wdt_pkg::count_off, v); chk(v, 8'h00);
        rd(wdt_pkg::compare_off, v); chk(v, 8'h7f);
        $display("test clear done");
        // System source holds its count in stop and resumes after it.
        stop_mode <= 1'b1;
        repeat (4) @(posedge clk);
        rd(wdt_pkg::count_off, v);
        repeat (5000) @(posedge clk);
        rd(wdt_pkg::count_off, w); chk(w, v);
        stop_mode <= 1'b0;
        n = 0;
        while (w === v && n < 5000) begin
            rd(wdt_pkg::count_off, w);
            n++;
        end
        chk({7'h0, w !== v}, 8'h01);
        $display("test stop done");
        // RC source keeps counting in stop; each tick is 256 RC rising edges.
        wr(wdt_pkg::clkctl_off, 8'h20);
        wr(wdt_pkg::compare_off, 8'h81);
        rd(wdt_pkg::status_off, v);
        stop_mode <= 1'b1;
        rc_rises <= 0;
        rc_run <= 1'b1;
        wait_ev(1'b0, 20000);
        chk({7'h0, rc_rises >= 256 && rc_rises <= 520}, 8'h01);
        rc_run <= 1'b0;
        stop_mode <= 1'b0;
        $display("test rc source done");
        // Reset mode waits for the interval clear, then pulses reset.
        sub_clock_mode <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({7'h0, main_osc_on}, 8'h00);
        wr(wdt_pkg::clkctl_off, 8'h10);
        wr(wdt_pkg::compare_off, 8'h81);
        rd(wdt_pkg::status_off, v);
        repeat (3000) @(posedge clk);
        rd(wdt_pkg::count_off, v); chk(v, 8'h00);
        chk({7'h0, chip_reset_n}, 8'h01);
        wr(wdt_pkg::clkctl_off, 8'h18);
        wait_ev(1'b1, 20000);
        n = 0;
        while (chip_reset_n === 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
            #1;
        end
        chk(n[7:0], 8'(wdt_pkg::rst_pulse_cycles));
        chk({7'h0, main_osc_on}, 8'h01);
        rd(wdt_pkg::status_off, v); chk(v & 8'h01, 8'h00);
        sub_clock_mode <= 1'b0;
        $display("test reset mode done");
        report_and_stop();
    end
endmodule : watchdog_timer_7bit_tb
`default_nettype wire

// >>> wdt_interval.sv
// Basic interval timer: prescaler and eight-bit free-running counter.
`timescale 1ns/1ps
`default_nettype none
module wdt_interval (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control.
    input wire logic [2:0] prescale_sel,
    input wire logic clear,
    input wire logic run,
    // Results.
    output logic tick,
    output logic overflow,
    output logic [7:0] count_q
);
    // Prescaler; divide ratio is 8 shifted by the select field.
    logic [9:0] pre_q;
    logic pre_hit;

    // A tick occurs when the selected prescaler bits are all ones, just before they wrap.
    always_comb begin
        pre_hit = run && ((pre_q & ((10'h8 << prescale_sel) - 10'h1))
                  == ((10'h8 << prescale_sel) - 10'h1));
    end

    // Clearing restarts both prescaler and counter from zero.
    always_ff @(posedge clk) begin
        if (rst || clear) begin // RQ15
            pre_q <= 10'h000;
        end else if (run) begin
            pre_q <= pre_q + 10'h1;
        end
    end

    // Counter advances on each prescaled tick.
    always_ff @(posedge clk) begin
        if (rst || clear) begin // RQ15
            count_q <= 8'h00;
        end else if (pre_hit) begin
            count_q <= count_q + 8'h01;
        end
    end

    assign tick = pre_hit && !clear;
    assign overflow = tick && (count_q == 8'hff);
endmodule : wdt_interval
`default_nettype wire

// >>> wdt_pkg.sv
// Package with the register map, field positions and timing counts.
//
// Function
// RQ1 - Counter clocked by RC or interval tick.
// RQ2 - Seven-bit counter matched against compare bits.
// RQ3 - Match resets chip or sets interrupt flag.
// RQ4 - Clear bit clears counter, self-clears.
// RQ5 - Counting starts after interval timer cleared; the code also arms at once while reset-select is zero or RC is selected.
// RQ6 - RC select keeps counting during stop.
// RQ7 - RC tick divided by 256 first.
// RQ8 - Interval source: event every compare+1 ticks.
// RQ9 - Reset-select bit is zero after reset.
// RQ10 - No watchdog reset before software enables.
// RQ11 - System source halts in stop, holds value.
// RQ12 - Software clears counter before each timeout.
// RQ13 - Watchdog reset restarts main oscillator.
// RQ14 - Interrupt generation sets the interrupt flag.
// RQ15 - Interval clear bit restarts timer, self-clears.
// RQ16 - Clear beats a simultaneous compare match.
package wdt_pkg;
    // Register word offsets on the plain register port.
    localparam logic [3:0] compare_off = 4'h0;
    localparam logic [3:0] clkctl_off = 4'h1;
    localparam logic [3:0] status_off = 4'h2;
    localparam logic [3:0] mask_off = 4'h3;
    localparam logic [3:0] count_off = 4'h4;
    // Field positions in the clock control register.
    localparam int prescale_lsb = 0;
    localparam int interval_clear_bit = 3;
    localparam int reset_select_bit = 4;
    localparam int rc_select_bit = 5;
    // Field position of the counter clear bit in the compare register.
    localparam int counter_clear_pos = 7;
    // Status bit positions.
    localparam int st_timeout = 0;
    localparam int st_interval = 1;
    // Reset values.
    localparam logic [7:0] compare_rst = 8'hff;
    localparam logic [7:0] clkctl_rst = 8'h00;
    // The RC tick is divided by two to the eighth before the counter.
    localparam int rc_div_bits = 8;
    // Length of the chip reset pulse driven on a watchdog reset.
    localparam int rst_pulse_cycles = 4;
endpackage : wdt_pkg

// >>> wdt_top.sv
// Watchdog timer with seven-bit counter, compare register and RC source.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module wdt_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // Power and clock pins.
    input wire logic stop_mode,
    input wire logic sub_clock_mode,
    input wire logic rc_osc,
    // Outputs.
    output logic chip_reset_n,
    output logic main_osc_on,
    output logic irq
);
    // Software-visible registers.
    logic [7:0] compare_q;
    logic [7:0] clkctl_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic counter_clear_q;
    logic interval_clear_q;
    // Watchdog state.
    logic [6:0] wdt_cnt_q;
    logic armed_q;
    logic [2:0] rst_cnt_q;
    logic reset_req_q;
    logic osc_on_q;
    // Synchroniser and divider for the RC oscillator.
    logic rc_s1_q;
    logic rc_s2_q;
    logic rc_s3_q;
    logic [7:0] rc_div_q;
    // Stop and sub clock modes from the power controller, synchronised.
    logic stop_s1_q;
    logic stop_q;
    logic sub_s1_q;
    logic sub_q;
    // Previous synchronised sub clock level, for spotting its entry.
    logic sub_prev_q;
    // Interval timer wires.
    logic bit_tick;
    logic bit_ovf;
    logic [7:0] bit_cnt;
    // Derived strobes.
    logic wr_compare;
    logic wr_clkctl;
    logic rd_status;
    logic rc_sel;
    logic rc_tick;
    logic wdt_tick;
    logic match;
    logic timeout;

    // Write and read decodes, and the RC source select.
    assign wr_compare = wr_en && (addr == wdt_pkg::compare_off);
    assign wr_clkctl = wr_en && (addr == wdt_pkg::clkctl_off);
    assign rd_status = rd_en && (addr == wdt_pkg::status_off);
    assign rc_sel = clkctl_q[wdt_pkg::rc_select_bit];

    // Interval timer; it halts with the main clock in stop mode.
    wdt_interval u_interval (
        .clk(clk),
        .rst(rst),
        .prescale_sel(clkctl_q[2:0]),
        .clear(interval_clear_q),
        .run(!stop_q),
        .tick(bit_tick),
        .overflow(bit_ovf),
        .count_q(bit_cnt)
    );

    // Two flip-flops catch the asynchronous pins before use.
    always_ff @(posedge clk) begin
        if (rst) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
            stop_s1_q <= 1'b0;
            stop_q <= 1'b0;
            sub_s1_q <= 1'b0;
            sub_q <= 1'b0;
            sub_prev_q <= 1'b0;
        end else begin
            rc_s1_q <= rc_osc;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
            stop_s1_q <= stop_mode;
            stop_q <= stop_s1_q;
            sub_s1_q <= sub_clock_mode;
            sub_q <= sub_s1_q;
            sub_prev_q <= sub_q;
        end
    end

    // The RC divider counts every RC rising edge, regardless of stop mode and of the source select.
    always_ff @(posedge clk) begin
        if (rst) begin
            rc_div_q <= 8'h00;
        end else if (rc_s2_q && !rc_s3_q) begin
            rc_div_q <= rc_div_q + 8'h01; // RQ7
        end
    end

    // A divided RC tick fires when the divider wraps past 255.
    assign rc_tick = rc_s2_q && !rc_s3_q && (rc_div_q == 8'hff); // RQ7

    // Source select; the system tick is blocked in stop mode.
    always_comb begin
        if (rc_sel) begin
            wdt_tick = rc_tick; // RQ1 RQ6
        end else begin
            wdt_tick = bit_tick && !stop_q; // RQ1 RQ11
        end
    end

    // Compare register with its self-clearing counter clear bit.
    always_ff @(posedge clk) begin
        if (rst) begin
            compare_q <= wdt_pkg::compare_rst;
            counter_clear_q <= 1'b0;
        end else begin
            counter_clear_q <= 1'b0; // RQ4
            if (wr_compare) begin
                compare_q <= {1'b0, wdata[6:0]};
                counter_clear_q <= wdata[wdt_pkg::counter_clear_pos]; // RQ4
            end
        end
    end

    // Clock control register; the interval clear bit self-clears.
    always_ff @(posedge clk) begin
        if (rst) begin
            clkctl_q <= wdt_pkg::clkctl_rst; // RQ9
            interval_clear_q <= 1'b0;
        end else begin
            interval_clear_q <= 1'b0; // RQ15
            if (wr_clkctl) begin
                clkctl_q <= {2'b00, wdata[5:4], 1'b0, wdata[2:0]};
                interval_clear_q <= wdata[wdt_pkg::interval_clear_bit];
            end
        end
    end

    // Counting is armed once the interval timer is cleared or the RC source is selected, and always while reset-select is zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (wr_clkctl && !clkctl_q[wdt_pkg::reset_select_bit]
                     && wdata[wdt_pkg::reset_select_bit]) begin
            armed_q <= 1'b0; // RQ5
        end else if (interval_clear_q || rc_sel) begin
            armed_q <= 1'b1; // RQ5
        end else if (!clkctl_q[wdt_pkg::reset_select_bit]) begin
            armed_q <= 1'b1;
        end
    end

    // Match of counter value with the low seven compare bits.
    assign match = (wdt_cnt_q == compare_q[6:0]); // RQ2
    assign timeout = wdt_tick && armed_q && match && !counter_clear_q; // RQ16

    // Seven-bit counter: clear wins, else restart on match, else count.
    always_ff @(posedge clk) begin
        if (rst || counter_clear_q) begin
            wdt_cnt_q <= 7'h00; // RQ4 RQ16
        end else if (wdt_tick && armed_q) begin
            if (match) begin
                wdt_cnt_q <= 7'h00; // RQ8
            end else begin
                wdt_cnt_q <= wdt_cnt_q + 7'h01; // RQ2
            end
        end
    end

    // Chip reset pulse when reset-select is set at timeout.
    always_ff @(posedge clk) begin
        if (rst) begin
            rst_cnt_q <= 3'h0;
            reset_req_q <= 1'b0;
        end else if (timeout && clkctl_q[wdt_pkg::reset_select_bit]) begin
            rst_cnt_q <= 3'(wdt_pkg::rst_pulse_cycles - 1); // RQ3 RQ10
            reset_req_q <= 1'b1;
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end else begin
            reset_req_q <= 1'b0;
        end
    end

    assign chip_reset_n = !reset_req_q; // RQ3

    // Main oscillator is re-enabled by a watchdog reset in sub clock mode.
    // It stays on afterwards; only a fresh entry into sub clock stops it,
    // so the reset pulse cannot be undone one cycle later.
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_on_q <= 1'b1;
        end else if (timeout && clkctl_q[wdt_pkg::reset_select_bit]) begin
            osc_on_q <= 1'b1; // RQ13
        end else if (!sub_q) begin
            osc_on_q <= 1'b1;
        end else if (!sub_prev_q) begin
            osc_on_q <= 1'b0;
        end
    end

    assign main_osc_on = osc_on_q;

    // Sticky status bits; a hardware set wins over the read clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= 2'b00;
        end else begin
            status_q[wdt_pkg::st_timeout] <= (timeout
                && !clkctl_q[wdt_pkg::reset_select_bit]) // RQ3 RQ14
                || (status_q[wdt_pkg::st_timeout] && !rd_status);
            status_q[wdt_pkg::st_interval] <= bit_ovf
                || (status_q[wdt_pkg::st_interval] && !rd_status);
        end
    end

    // Interrupt mask register.
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= 2'b00;
        end else if (wr_en && addr == wdt_pkg::mask_off) begin
            mask_q <= wdata[1:0];
        end
    end

    assign irq = |(status_q & mask_q);

    // Read data register; unmapped offsets read as zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            unique case (addr)
                // The clear bit always reads back as zero.
                wdt_pkg::compare_off: rdata <= {1'b0, compare_q[6:0]}; // RQ4
                wdt_pkg::clkctl_off: rdata <= bit_cnt;
                wdt_pkg::status_off: rdata <= {6'h00, status_q};
                wdt_pkg::mask_off: rdata <= {6'h00, mask_q};
                wdt_pkg::count_off: rdata <= {1'b0, wdt_cnt_q};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Checks on the watchdog behaviour.
    a_clear_zeroes: assert property (@(posedge clk) disable iff (rst)
        counter_clear_q |=> wdt_cnt_q == 7'h00) // RQ4
        else $error("counter not cleared");
    a_clear_self: assert property (@(posedge clk) disable iff (rst)
        wr_compare |=> ##1 !counter_clear_q) // RQ4
        else $error("clear bit stuck");
    a_no_reset_off: assert property (@(posedge clk) disable iff (rst)
        !clkctl_q[4] && !reset_req_q |=> chip_reset_n) // RQ10
        else $error("reset while disabled");
    a_reset_on_hit: assert property (@(posedge clk) disable iff (rst)
        timeout && clkctl_q[4] |=> !chip_reset_n[*4]) // RQ3
        else $error("reset pulse wrong");
    a_flag_on_hit: assert property (@(posedge clk) disable iff (rst)
        timeout && !clkctl_q[4] |=> status_q[0]) // RQ14
        else $error("flag not set");
    a_clear_priority: assert property (@(posedge clk) disable iff (rst)
        counter_clear_q |-> !timeout) // RQ16
        else $error("timeout during clear");
    a_stop_holds: assert property (@(posedge clk) disable iff (rst)
        stop_q && !rc_sel && !counter_clear_q |=> $stable(wdt_cnt_q)) // RQ11
        else $error("counted in stop");
    a_match_restart: assert property (@(posedge clk) disable iff (rst)
        timeout |=> wdt_cnt_q == 7'h00) // RQ8
        else $error("no restart");
    a_sel_reset: assert property (@(posedge clk)
        rst |=> !clkctl_q[4]) // RQ9
        else $error("select not cleared");
    c_timeout_irq: cover property (@(posedge clk) timeout && !clkctl_q[4]);
    c_timeout_rst: cover property (@(posedge clk) timeout && clkctl_q[4]);
    c_rc_stop: cover property (@(posedge clk) rc_tick && stop_q && rc_sel);
endmodule : wdt_top
`default_nettype wire
